// ===== hdl/tsens_cfg.svh
/*
 * Constants of the two-wire slave port: bus address, register reset values,
 * field positions and the bus time-out figures.
 * Assumes inclusion by bare name from the port module and the testbench.
 */
`ifndef TSENS_CFG_SVH
`define TSENS_CFG_SVH

// fixed upper nibble of the slave address, bits 7..4
`define ADDR_FIXED_NIBBLE 4'h9
// bit positions inside the address byte
`define ADDR_PINS_MSB 3
`define ADDR_PINS_LSB 1
`define ADDR_RW_BIT 0
// bit count of one byte; the ninth clock is the acknowledge slot
`define BYTE_BITS 4'h8
`define BYTE_LAST_BIT 4'h7
`define MSB_INDEX 4'h7
// pointer field inside the pointer byte
`define PTR_MSB 1
`define PTR_LSB 0
// reset values
`define CONF_RESET 8'h00
`define OVER_RESET 16'h5000
`define HYST_RESET 16'h4B00
// serial-interface reset when data stays low: 75 ms minimum, 325 ms maximum
`define TIMEOUT_MIN_MS 75
`define TIMEOUT_MAX_MS 325
`define REF_CLK_HZ 20000000
`define TIMEOUT_CYCLES (`TIMEOUT_MIN_MS * (`REF_CLK_HZ / 1000))
`define TIMEOUT_CNT_MSB 20

`endif

// ===== hdl/tsens_pkg.sv
/*
 * Types of the two-wire slave port: engine states and pointer codes.
 * Assumes tsens_cfg.svh for the numeric constants.
 */
package tsens_pkg;

    // serial engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ADDR  = 2'h1,
        ST_WRITE = 2'h2,
        ST_READ  = 2'h3
    } state_t;

    // register selected by the low two pointer bits
    typedef enum logic [1:0] {
        PTR_TEMP = 2'h0,
        PTR_CONF = 2'h1,
        PTR_HYST = 2'h2,
        PTR_OVER = 2'h3
    } ptr_t;

endpackage

// ===== hdl/link_if.sv
/*
 * Carrier between the link capture front end and the serial engine.
 * Assumes every signal is already in the reference clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

interface link_if;
    logic scl_level;
    logic sda_level;
    logic bit_rise;
    logic rx_bit;

    modport capture (output scl_level, output sda_level, output bit_rise, output rx_bit);
    modport engine (input scl_level, input sda_level, input bit_rise, input rx_bit);
endinterface

`default_nettype wire

// ===== hdl/link_capture.sv
/*
 * Link front end: samples the data line on each rising serial clock edge in
 * the serial clock domain and hands bit and edge to the reference domain by
 * a toggle; also synchronises both line levels.
 * Assumes the serial clock stands still between frames.
 */
`timescale 1ns/10ps
`default_nettype none

module link_capture (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    link_if.capture link
);
    logic cap_bit;
    logic cap_tog;
    logic [2:0] sync_m;
    logic [2:0] sync_s;
    logic tog_d;
    logic rise_q;
    logic rx_q;

    // serial clock domain: data is stable while the clock is high
    always_ff @(posedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            cap_bit <= 1'b0;
            cap_tog <= 1'b0;
        end else begin
            cap_bit <= sda_i;
            cap_tog <= ~cap_tog;
        end
    end

    // two-flop synchronisers for toggle and both line levels
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_m <= 3'h3;
            sync_s <= 3'h3;
            tog_d <= 1'b0;
        end else begin
            sync_m <= {cap_tog, sda_i, scl_i};
            sync_s <= sync_m;
            tog_d <= sync_s[2];
        end
    end

    // cap_bit is settled for two reference cycles once the toggle arrives
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_q <= 1'b0;
            rx_q <= 1'b1;
        end else begin
            rise_q <= sync_s[2] ^ tog_d;
            if (sync_s[2] ^ tog_d) begin
                rx_q <= cap_bit;
            end
        end
    end

    assign link.scl_level = sync_s[0];
    assign link.sda_level = sync_s[1];
    assign link.bit_rise = rise_q;
    assign link.rx_bit = rx_q;
endmodule

`default_nettype wire

// ===== hdl/temp_sensor_i2c_slave_port.sv
/*
 * Two-wire slave port of a temperature sensor: START/STOP detection,
 * address match, acknowledge, pointer load, register writes and reads,
 * bus time-out.
 * Assumes an external master drives the serial clock; temperature data
 * arrives on the reference clock.
 */
// Functional notes
// - slave only, never drives the clock
// - nine clocks per byte, MSB first
// - address 1001 plus strap pins, bit0 direction
// - data changes only while clock low
// - data fall with clock high starts transaction
// - data rise with clock high ends transaction
// - no byte-count limit per transaction
// - receiver acknowledges low across ninth clock
// - release data line after master not-acknowledge
// - first written byte loads register pointer
// - read uses held pointer or freshly set
// - pointer selects temperature after reset
// - long data-low time-out resets serial interface
// - config one byte, others two, high first
`include "tsens_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module temp_sensor_i2c_slave_port #(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic addr_select_pin_2_i,
    input wire logic addr_select_pin_1_i,
    input wire logic addr_select_pin_0_i,
    input wire logic [8:0] temp_data_i,
    output logic [7:0] conf_o,
    output logic [8:0] over_limit_trip_point_o,
    output logic [8:0] hysteresis_trip_point_o,
    output tsens_pkg::ptr_t pointer_byte_o
);
    import tsens_pkg::*;

    localparam logic [`TIMEOUT_CNT_MSB:0] TO_LIMIT = TIMEOUT_CYCLES[`TIMEOUT_CNT_MSB:0];

    // address byte match against the fixed nibble and the strap pins
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] pins);
        return (b[7:4] == `ADDR_FIXED_NIBBLE) &&
               (b[`ADDR_PINS_MSB:`ADDR_PINS_LSB] == pins);
    endfunction

    // byte presented for a read of the selected register
    function automatic logic [7:0] read_byte(input ptr_t p, input logic low_half,
                                             input logic [8:0] temp, input logic [7:0] conf,
                                             input logic [8:0] over, input logic [8:0] hyst);
        logic [8:0] val;
        val = temp;
        case (p)
            PTR_CONF: return conf;
            PTR_OVER: val = over;
            PTR_HYST: val = hyst;
            default: val = temp;
        endcase
        return low_half ? {val[0], 7'h00} : val[8:1];
    endfunction

    link_if link();
    logic [2:0] addr_m;
    logic [2:0] addr_s;
    logic scl_prev;
    logic sda_prev;
    logic [`TIMEOUT_CNT_MSB:0] to_cnt;
    state_t state;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic ack_pending;
    logic [7:0] rx_shift;
    logic [7:0] tx_byte;
    logic low_half;
    logic drive_low;
    ptr_t pointer;
    logic [7:0] conf;
    logic [8:0] over;
    logic [8:0] hyst;
    logic [8:0] temp_hold;
    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic timed_out;
    logic byte_done;
    logic ack_slot;
    logic [7:0] new_byte;

    link_capture u_capture (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .link(link.capture)
    );

    // strap pins come from outside: two flops before use
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_m <= 3'h0;
            addr_s <= 3'h0;
        end else begin
            addr_m <= {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i};
            addr_s <= addr_m;
        end
    end

    // line history for edge and condition detection
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= link.scl_level;
            sda_prev <= link.sda_level;
        end
    end

    // bus conditions: data moves while the clock stays high
    assign start_det = scl_prev & link.scl_level & sda_prev & ~link.sda_level;
    assign stop_det = scl_prev & link.scl_level & ~sda_prev & link.sda_level;
    assign scl_fall = scl_prev & ~link.scl_level;
    assign byte_done = link.bit_rise && (bit_cnt == `BYTE_LAST_BIT) && (state != ST_IDLE);
    assign ack_slot = link.bit_rise && (bit_cnt == `BYTE_BITS) && (state != ST_IDLE);
    assign new_byte = {rx_shift[6:0], link.rx_bit};
    assign timed_out = (to_cnt == TO_LIMIT);

    // data-low time-out counter, saturates at the limit
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            to_cnt <= '0;
        end else if (link.sda_level) begin
            to_cnt <= '0;
        end else if (!timed_out) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // serial engine: one nine-clock group per byte, unlimited bytes
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            ack_pending <= 1'b0;
            rx_shift <= 8'h00;
            tx_byte <= 8'h00;
            low_half <= 1'b0;
        end else if (timed_out) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            ack_pending <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            ack_pending <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            ack_pending <= 1'b0;
        end else if (ack_slot) begin
            bit_cnt <= 4'h0;
            case (state)
                ST_ADDR: begin
                    if (!ack_pending) begin
                        state <= ST_IDLE;
                    end else if (rx_shift[`ADDR_RW_BIT]) begin
                        state <= ST_READ;
                        tx_byte <= read_byte(pointer, 1'b0, temp_hold, conf, over, hyst);
                        low_half <= 1'b1;
                    end else begin
                        state <= ST_WRITE;
                        byte_idx <= 2'h0;
                    end
                    ack_pending <= 1'b0;
                end
                ST_WRITE: begin
                    ack_pending <= 1'b0;
                end
                ST_READ: begin
                    if (link.rx_bit) begin
                        state <= ST_IDLE;
                    end else begin
                        // two-byte registers alternate high then low
                        tx_byte <= read_byte(pointer, low_half, temp_hold, conf, over, hyst);
                        low_half <= (pointer == PTR_CONF) ? 1'b0 : ~low_half;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end else if (link.bit_rise && state != ST_IDLE) begin
            bit_cnt <= bit_cnt + 4'h1;
            rx_shift <= new_byte;
            if (byte_done && state == ST_ADDR) begin
                ack_pending <= addr_hit(new_byte, addr_s);
            end else if (byte_done && state == ST_WRITE) begin
                ack_pending <= 1'b1;
                if (byte_idx != 2'h3) begin
                    byte_idx <= byte_idx + 2'h1;
                end
            end
        end
    end

    // pointer and writable registers; kept across time-outs and restarts
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pointer <= PTR_TEMP;
            conf <= `CONF_RESET;
            over <= 9'(`OVER_RESET >> 7);
            hyst <= 9'(`HYST_RESET >> 7);
        end else if (byte_done && state == ST_WRITE && !timed_out && !start_det && !stop_det) begin
            if (byte_idx == 2'h0) begin
                pointer <= ptr_t'(new_byte[`PTR_MSB:`PTR_LSB]);
            end else begin
                case (pointer)
                    PTR_CONF: begin
                        if (byte_idx == 2'h1) begin
                            conf <= new_byte;
                        end
                    end
                    PTR_OVER: begin
                        if (byte_idx == 2'h1) begin
                            over[8:1] <= new_byte;
                        end else if (byte_idx == 2'h2) begin
                            over[0] <= new_byte[7];
                        end
                    end
                    PTR_HYST: begin
                        if (byte_idx == 2'h1) begin
                            hyst[8:1] <= new_byte;
                        end else if (byte_idx == 2'h2) begin
                            hyst[0] <= new_byte[7];
                        end
                    end
                    default: begin
                        pointer <= pointer; // temperature is read-only
                    end
                endcase
            end
        end
    end

    // temperature is frozen while a read is in progress
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            temp_hold <= 9'h000;
        end else if (state != ST_READ) begin
            temp_hold <= temp_data_i;
        end
    end

    // data line drive changes only after the clock has fallen, except the release on time-out, start, stop or idle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_low <= 1'b0;
        end else if (timed_out || start_det || stop_det || state == ST_IDLE) begin
            drive_low <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                ST_ADDR, ST_WRITE: begin
                    drive_low <= (bit_cnt == `BYTE_BITS) && ack_pending;
                end
                ST_READ: begin
                    drive_low <= (bit_cnt < `BYTE_BITS) &&
                                 !tx_byte[3'(`MSB_INDEX - bit_cnt)];
                end
                default: begin
                    drive_low <= 1'b0;
                end
            endcase
        end
    end

    // open-drain data pin; the clock pin is input only
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drive_low;
    assign conf_o = conf;
    assign over_limit_trip_point_o = over;
    assign hysteresis_trip_point_o = hyst;
    assign pointer_byte_o = pointer;
    // checks on the engine
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_idle_release: assert property (state == ST_IDLE |-> !drive_low)
        else $error("data line driven while idle");
    chk_start_enter: assert property (start_det && !timed_out |=> state == ST_ADDR && bit_cnt == 4'h0)
        else $error("start did not open a transaction");
    chk_stop_leave: assert property (stop_det && !start_det |=> state == ST_IDLE && !drive_low)
        else $error("stop did not end the transaction");
    chk_ack_held: assert property (scl_fall && bit_cnt == 4'h8 && ack_pending && !timed_out &&
                                   (state == ST_ADDR || state == ST_WRITE) |=> drive_low [*8])
        else $error("acknowledge not held low");
    chk_addr_decode: assert property (byte_done && state == ST_ADDR && !timed_out && !start_det &&
                                      !stop_det |=> ack_pending == addr_hit($past(new_byte), $past(addr_s)))
        else $error("address match wrong");
    chk_addr_miss: assert property (ack_slot && state == ST_ADDR && !ack_pending && !timed_out &&
                                    !start_det && !stop_det |=> state == ST_IDLE)
        else $error("missed address not ignored");
    chk_pointer_load: assert property (byte_done && state == ST_WRITE && byte_idx == 2'h0 && !timed_out &&
                                       !start_det && !stop_det |=> pointer == ptr_t'($past(new_byte[1:0])))
        else $error("pointer not loaded from first byte");
    chk_nack_end: assert property (ack_slot && state == ST_READ && link.rx_bit && !timed_out && !start_det &&
                                   !stop_det |=> state == ST_IDLE ##1 !drive_low)
        else $error("no release after not-acknowledge");
    chk_timeout_count: assert property (!link.sda_level && !timed_out |=> to_cnt == $past(to_cnt) + 1'b1)
        else $error("time-out counter stalled");
    chk_timeout_reset: assert property (timed_out |=> state == ST_IDLE && !drive_low)
        else $error("time-out did not reset interface");
    chk_bit_frame: assert property (link.bit_rise && state != ST_IDLE && !start_det && !stop_det &&
                                    !timed_out |=> bit_cnt == (($past(bit_cnt) == 4'h8) ? 4'h0 :
                                    $past(bit_cnt) + 4'h1))
        else $error("bit count out of frame");
    cov_pointer_write: cover property (byte_done && state == ST_WRITE && byte_idx == 2'h0);
    cov_read_two: cover property (ack_slot && state == ST_READ && !link.rx_bit && low_half);
    cov_read_nack: cover property (ack_slot && state == ST_READ && link.rx_bit);
    cov_timeout: cover property (timed_out && state != ST_IDLE);
endmodule

`default_nettype wire

// ===== tb/bus_master_model.sv
/*
 * Behavioural two-wire bus master: start, stop, byte write and byte read.
 * Assumes an open-drain data line with pull-up, resolved by the bench.
 * The serial clock stands still between frames.
 */
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
    input wire logic link_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_low_o
);
    // quarter bit in base clock ticks: 300 ns
    localparam int QUARTER = 10;

    // idle bus: clock high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    // start or repeated start; the first call finds the bus idle
    task automatic start_cond();
        sda_low_o = 1'b0;
        ticks(QUARTER);
        scl_o = 1'b1;
        ticks(2 * QUARTER);
        sda_low_o = 1'b1;
        ticks(2 * QUARTER);
        scl_o = 1'b0;
        ticks(QUARTER);
    endtask

    task automatic stop_cond();
        sda_low_o = 1'b1;
        ticks(QUARTER);
        scl_o = 1'b1;
        ticks(2 * QUARTER);
        sda_low_o = 1'b0;
        ticks(2 * QUARTER);
    endtask

    // one clock pulse per bit, data changed only while clock low
    task automatic clock_bit(input logic b, output logic got);
        sda_low_o = ~b;
        ticks(QUARTER);
        scl_o = 1'b1;
        ticks(QUARTER);
        got = sda_line_i;
        ticks(QUARTER);
        scl_o = 1'b0;
        ticks(QUARTER);
    endtask

    // eight bits, most significant first
    task automatic send_bits(input logic [7:0] d);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], dummy);
        end
    endtask

    // ninth clock carries the device acknowledge
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic got;
        send_bits(d);
        clock_bit(1'b1, got);
        ack = ~got;
    endtask

    // read a byte, then acknowledge or withhold it
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(~ack, dummy);
    endtask
endmodule

`default_nettype wire

// ===== tb/test_temp_sensor_i2c_slave_port.sv
/*
 * Self-checking bench of the temperature sensor slave port.
 * Assumes the master model clocks the bus; data line pulled up.
 */
`include "tsens_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module test_temp_sensor_i2c_slave_port;
    import tsens_pkg::*;
    localparam int TO_CYCLES = 2000;
    logic ref_clk, link_clk, rst, scl, sda_low, sda_line, sda_zero, sda_oe_n;
    logic [2:0] pins = 3'h5;
    logic [8:0] temp = 9'h0C5;
    logic [8:0] over, hyst;
    logic [7:0] conf;
    ptr_t ptr;
    int fails = 0;
    int samples_checked = 0;

    // open-drain data line with pull-up
    assign sda_line = ~sda_low & (sda_oe_n | sda_zero);

    // reference clock, 50 ns
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // link base clock, 30 ns, shifted phase
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    temp_sensor_i2c_slave_port #(.TIMEOUT_CYCLES(TO_CYCLES)) uut (
        .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_zero), .sda_oe_n_o(sda_oe_n), .addr_select_pin_2_i(pins[2]),
        .addr_select_pin_1_i(pins[1]), .addr_select_pin_0_i(pins[0]), .temp_data_i(temp),
        .conf_o(conf), .over_limit_trip_point_o(over), .hysteresis_trip_point_o(hyst),
        .pointer_byte_o(ptr));
    bus_master_model master (.link_clk_i(link_clk), .sda_line_i(sda_line), .scl_o(scl),
        .sda_low_o(sda_low));

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_line(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] addr(input logic rw);
        return {`ADDR_FIXED_NIBBLE, pins, rw};
    endfunction

    // pointer write followed by n data bytes, each acknowledged
    task automatic write_reg(input logic [7:0] p, input logic [7:0] b0, input logic [7:0] b1,
                             input int n);
        logic ack;
        master.start_cond();
        master.write_byte(addr(1'b0), ack);
        check_line(ack, 1'b1);
        master.write_byte(p, ack);
        check_line(ack, 1'b1);
        if (n > 0) begin
            master.write_byte(b0, ack);
            check_line(ack, 1'b1);
        end
        if (n > 1) begin
            master.write_byte(b1, ack);
            check_line(ack, 1'b1);
        end
        master.stop_cond();
    endtask

    // two-byte read, optionally after a pointer write and repeated start
    task automatic read_reg(input logic set, input logic [7:0] p, output logic [7:0] b0,
                            output logic [7:0] b1);
        logic ack;
        master.start_cond();
        if (set) begin
            master.write_byte(addr(1'b0), ack);
            master.write_byte(p, ack);
            check_line(ack, 1'b1);
            master.start_cond();
        end
        master.write_byte(addr(1'b1), ack);
        check_line(ack, 1'b1);
        master.read_byte(1'b1, b0);
        master.read_byte(1'b0, b1);
        master.ticks(4);
        check_line(sda_line, 1'b1);
        master.stop_cond();
    endtask

    task automatic t_reset();
        check_val(16'(conf), 16'(`CONF_RESET));
        check_val(16'(over), 16'(`OVER_RESET >> 7));
        check_val(16'(hyst), 16'(`HYST_RESET >> 7));
        check_val(16'(ptr), 16'(PTR_TEMP));
        check_line(sda_zero, 1'b0);
        $display("test reset done");
    endtask

    // preset-pointer temperature read under two strap settings
    task automatic t_temp();
        logic [2:0] straps [2] = '{3'h5, 3'h2};
        logic [7:0] b0, b1;
        logic [15:0] w;
        foreach (straps[i]) begin
            @(negedge ref_clk);
            pins = straps[i];
            repeat (4) @(negedge ref_clk);
            w = {temp, 7'h00};
            read_reg(1'b0, 8'h00, b0, b1);
            check_val({b0, b1}, w);
        end
        $display("test temperature read done");
    endtask

    task automatic t_miss();
        logic [7:0] bad [3] = '{8'h9A, 8'h1A, 8'hDA};
        logic ack;
        foreach (bad[i]) begin
            master.start_cond();
            master.write_byte(bad[i], ack);
            check_line(ack, 1'b0);
            master.write_byte(8'h01, ack);
            check_line(ack, 1'b0);
            master.stop_cond();
        end
        check_val(16'(ptr), 16'(PTR_TEMP));
        $display("test address miss done");
    endtask

    // upper pointer bits ignored; extra byte dropped; config repeats
    task automatic t_conf();
        logic [7:0] b0, b1;
        write_reg(8'hFD, 8'h1E, 8'hA5, 2);
        check_val(16'(conf), 16'h001E);
        check_val(16'(ptr), 16'(PTR_CONF));
        read_reg(1'b1, 8'h01, b0, b1);
        check_val({b0, b1}, 16'h1E1E);
        $display("test config done");
    endtask

    task automatic t_trip();
        logic [7:0] p [2] = '{8'h03, 8'h02};
        logic [7:0] hi [2] = '{8'h55, 8'h3C};
        logic [7:0] lo [2] = '{8'hC0, 8'h7F};
        logic [7:0] b0, b1;
        foreach (p[i]) begin
            write_reg(p[i], hi[i], lo[i], 2);
            read_reg(1'b1, p[i], b0, b1);
            check_val({b0, b1}, {hi[i], lo[i] & 8'h80});
        end
        check_val(16'(over), 16'({8'h55, 1'b1}));
        check_val(16'(hyst), 16'({8'h3C, 1'b0}));
        read_reg(1'b0, 8'h00, b0, b1);
        check_val({b0, b1}, 16'h3C00);
        $display("test trip points done");
    endtask

    // clocking stops while the device holds its acknowledge low
    task automatic t_timeout();
        logic [7:0] b0, b1;
        master.start_cond();
        master.send_bits(addr(1'b0));
        master.ticks(4);
        check_line(sda_oe_n, 1'b0);
        repeat (TO_CYCLES + 100) @(posedge ref_clk);
        check_line(sda_oe_n, 1'b1);
        master.stop_cond();
        check_val(16'(ptr), 16'(PTR_HYST));
        read_reg(1'b0, 8'h00, b0, b1);
        check_val({b0, b1}, 16'h3C00);
        $display("test time-out done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        t_reset();
        t_temp();
        t_miss();
        t_conf();
        t_trip();
        t_timeout();
        report_and_stop();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
endmodule

`default_nettype wire
